// ---- inc/pwm_slice_defines.vh ----
// register map, field positions and reset values of the pwm slice
`ifndef PWM_SLICE_DEFINES_VH
`define PWM_SLICE_DEFINES_VH
// byte register offsets
`define OFS_CLOCK_PRESCALE 12'h0491
`define OFS_POSTSCALE 12'h0492
`define OFS_IRQ_FLAGS 12'h0493
`define OFS_IRQ_ENABLES 12'h0494
`define OFS_MODULE_CONTROL 12'h0495
`define OFS_PERIOD_LOWER 12'h048F
`define OFS_PERIOD_UPPER 12'h0490
`define OFS_SLICE_CONFIG 12'h0496
`define OFS_FIRST_LOWER 12'h0497
`define OFS_FIRST_UPPER 12'h0498
`define OFS_SECOND_LOWER 12'h0499
`define OFS_SECOND_UPPER 12'h049A
`define OFS_STATUS 12'h049B
// module control fields
`define CON_ENABLE 7
`define CON_RELOAD 2
`define CON_ERS_LOW 1
`define CON_ERS_NOW 0
// slice config fields
`define CFG_INV2 7
`define CFG_INV1 6
`define CFG_ALT 3
// modes
`define MODE_LEFT 3'h0
`define MODE_RIGHT 3'h1
`define MODE_CENTER 3'h2
`define MODE_VARIABLE 3'h3
`define MODE_SET 3'h4
`define MODE_TOGGLE 3'h5
// reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`endif

// ---- rtl/dual_output_pwm_slice.v ----
// dual output pwm slice with prescaler, postscaler and flags
//
// The strobed register port is this design's own decision.
`include "pwm_slice_defines.vh"

// Functional notes
// - period length is 16-bit clock count
// - period upper and lower bytes separately accessible
// - prescaler divides pwm clock by setting+1
// - period interrupt every postscale+1 period events
// - second flag set per mode event
// - first flag set per mode event
// - flags reach interrupt only when enabled
// - disable resets logic, keeps registers
// - reload copies buffers at period event
// - external reset polarity bit selects level
// - immediate reset stops counter next clock
// - deferred reset stops at period end
// - per-output polarity bit inverts output
// - push-pull alternates outputs each period
// - mode field decodes aligned modes
// - mode 100 sets output on match
// - mode 101 toggles output on match
// - reserved modes hold outputs in reset
// - first parameter 16-bit, resets zero
// - left/right aligned active n clocks
// - centre aligned active 2n clocks
// - variable aligned first sets, second clears
// - module flag ORs enabled parameter flags
module dual_output_pwm_slice #(
  parameter ADDR_W = 12
) (
  input wire mclk,
  input wire reset,
  input wire pwmClkEn,
  input wire extResetPin,
  input wire [ADDR_W-1:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  output reg first_output,
  output reg second_output,
  output reg periodIrq,
  output reg paramIrq,
  output reg module_irq_flag
);

////////////////////////////////////////////////////////////////////////////
// software registers
reg [7:0] clock_divide_setting_r;
reg [7:0] period_event_divider_r;
reg [1:0] irqFlags_r;
reg [1:0] irqEnables_r;
reg moduleEnable_r;
reg reload_request_r;
reg ext_reset_active_low_r;
reg ext_reset_immediate_r;
reg [15:0] period_count_r;
reg [7:0] sliceConfig_r;
reg [15:0] first_param_r;
reg [15:0] second_param_r;
// working state
reg [15:0] periodBuf_r;
reg [15:0] firstBuf_r;
reg [15:0] secondBuf_r;
reg [15:0] timer_r;
reg [7:0] prescaleCnt_r;
reg [7:0] postscaleCnt_r;
reg rawFirst_r;
reg rawSecond_r;
reg altPhase_r;
reg stopped_r;
reg stopPending_r;
reg extSync1_r;
reg extSync2_r;

wire [2:0] mode = sliceConfig_r[2:0];
wire wrHit = regWr;

////////////////////////////////////////////////////////////////////////////
// pin synchroniser
always @(posedge mclk) begin
  if (reset) begin
    extSync1_r <= 1'b0;
    extSync2_r <= 1'b0;
  end else begin
    extSync1_r <= extResetPin;
    extSync2_r <= extSync1_r;
  end
end

// external reset level after polarity selection
wire extActive = extSync2_r ^ ext_reset_active_low_r;

////////////////////////////////////////////////////////////////////////////
// prescaler tick and period event
wire prescaleTick = moduleEnable_r && pwmClkEn &&
  (prescaleCnt_r == clock_divide_setting_r);
wire running = !stopped_r;
wire tick = prescaleTick && running;
wire periodEvent = tick && (timer_r == periodBuf_r);
wire [15:0] nextTimer = periodEvent ? `RST_WORD : timer_r + 16'h0001;
wire firstMatch = tick && (nextTimer == firstBuf_r);
wire secondMatch = tick && (nextTimer == secondBuf_r);

// span used by right and centre alignment, wraps when the parameter exceeds the period
wire [15:0] spanFirst = periodBuf_r - firstBuf_r;
wire [15:0] spanSecond = periodBuf_r - secondBuf_r;

////////////////////////////////////////////////////////////////////////////
// raw waveform for each output at the next timer value
reg nxtFirst;
reg nxtSecond;
always @* begin
  nxtFirst = rawFirst_r;
  nxtSecond = rawSecond_r;
  case (mode)
    `MODE_LEFT: begin
      nxtFirst = nextTimer < firstBuf_r;
      nxtSecond = nextTimer < secondBuf_r;
    end
    `MODE_RIGHT: begin
      nxtFirst = (firstBuf_r != `RST_WORD) &&
        (nextTimer > spanFirst); // last n counts only
      nxtSecond = (secondBuf_r != `RST_WORD) &&
        (nextTimer > spanSecond);
    end
    `MODE_CENTER: begin
      nxtFirst = (nextTimer < firstBuf_r) ||
        (nextTimer > spanFirst); // n before and n after the event
      nxtSecond = (nextTimer < secondBuf_r) ||
        (nextTimer > spanSecond);
      if (firstBuf_r == `RST_WORD) nxtFirst = 1'b0;
      if (secondBuf_r == `RST_WORD) nxtSecond = 1'b0;
    end
    `MODE_VARIABLE: begin
      if (firstMatch) begin
        nxtFirst = 1'b1;
        nxtSecond = 1'b1;
      end
      if (secondMatch) begin
        nxtFirst = 1'b0;
        nxtSecond = 1'b0;
      end
    end
    `MODE_SET: begin
      if (firstMatch) nxtFirst = 1'b1;
      if (secondMatch) nxtSecond = 1'b1;
    end
    `MODE_TOGGLE: begin
      if (firstMatch) nxtFirst = !rawFirst_r;
      if (secondMatch) nxtSecond = !rawSecond_r;
    end
    default: begin
      nxtFirst = 1'b0;
      nxtSecond = 1'b0;
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////
// parameter flag events per mode
reg [1:0] paramEvent;
always @* begin
  paramEvent = 2'b00;
  case (mode)
    `MODE_LEFT: begin // trailing edge
      paramEvent[0] = tick && rawFirst_r && !nxtFirst;
      paramEvent[1] = tick && rawSecond_r && !nxtSecond;
    end
    `MODE_RIGHT: begin // leading edge
      paramEvent[0] = tick && !rawFirst_r && nxtFirst;
      paramEvent[1] = tick && !rawSecond_r && nxtSecond;
    end
    `MODE_CENTER: begin // any change
      paramEvent[0] = tick && (rawFirst_r != nxtFirst);
      paramEvent[1] = tick && (rawSecond_r != nxtSecond);
    end
    `MODE_VARIABLE, `MODE_SET, `MODE_TOGGLE: begin
      paramEvent[0] = firstMatch;
      paramEvent[1] = secondMatch;
    end
    default: paramEvent = 2'b00;
  endcase
end

////////////////////////////////////////////////////////////////////////////
// counter, prescaler, postscaler, external reset handling
always @(posedge mclk) begin
  if (reset || !moduleEnable_r) begin
    timer_r <= `RST_WORD;
    prescaleCnt_r <= `RST_BYTE;
    postscaleCnt_r <= `RST_BYTE;
    rawFirst_r <= 1'b0;
    rawSecond_r <= 1'b0;
    altPhase_r <= 1'b0;
    stopped_r <= 1'b0;
    stopPending_r <= 1'b0;
    periodIrq <= 1'b0;
  end else begin
    periodIrq <= 1'b0;
    if (pwmClkEn) begin
      if (prescaleCnt_r == clock_divide_setting_r)
        prescaleCnt_r <= `RST_BYTE;
      else
        prescaleCnt_r <= prescaleCnt_r + 8'h01;
    end
    if (extActive && !stopped_r) begin
      if (ext_reset_immediate_r && prescaleTick) begin
        stopped_r <= 1'b1;
        timer_r <= `RST_WORD;
        rawFirst_r <= 1'b0;
        rawSecond_r <= 1'b0;
      end else if (!ext_reset_immediate_r) begin
        stopPending_r <= 1'b1;
      end
    end
    if (stopped_r && !extActive && prescaleTick)
      stopped_r <= 1'b0;
    if (tick && !(extActive && ext_reset_immediate_r)) begin
      timer_r <= nextTimer;
      rawFirst_r <= nxtFirst;
      rawSecond_r <= nxtSecond;
      if (periodEvent) begin
        altPhase_r <= !altPhase_r;
        if (stopPending_r) begin
          stopped_r <= 1'b1;
          stopPending_r <= 1'b0;
          rawFirst_r <= 1'b0;
          rawSecond_r <= 1'b0;
        end
        if (postscaleCnt_r == period_event_divider_r) begin
          postscaleCnt_r <= `RST_BYTE;
          periodIrq <= 1'b1;
        end else begin
          postscaleCnt_r <= postscaleCnt_r + 8'h01;
        end
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// working buffers loaded on reload at period event
always @(posedge mclk) begin
  if (reset) begin
    periodBuf_r <= `RST_WORD;
    firstBuf_r <= `RST_WORD;
    secondBuf_r <= `RST_WORD;
  end else if (!moduleEnable_r) begin
    periodBuf_r <= period_count_r;
    firstBuf_r <= first_param_r;
    secondBuf_r <= second_param_r;
  end else if (periodEvent && reload_request_r) begin
    periodBuf_r <= period_count_r;
    firstBuf_r <= first_param_r;
    secondBuf_r <= second_param_r;
  end
end

////////////////////////////////////////////////////////////////////////////
// output polarity and push-pull steering
wire altOn = sliceConfig_r[`CFG_ALT];
wire gateFirst = rawFirst_r && (!altOn || !altPhase_r);
wire gateSecond = rawSecond_r && (!altOn || altPhase_r);
always @(posedge mclk) begin
  if (reset) begin
    first_output <= 1'b0;
    second_output <= 1'b0;
  end else begin
    first_output <= gateFirst ^ sliceConfig_r[`CFG_INV1];
    second_output <= gateSecond ^ sliceConfig_r[`CFG_INV2];
  end
end

////////////////////////////////////////////////////////////////////////////
// register writes and hardware-set flags
wire [1:0] flagNext = irqFlags_r | paramEvent;
always @(posedge mclk) begin
  if (reset) begin
    clock_divide_setting_r <= `RST_BYTE;
    period_event_divider_r <= `RST_BYTE;
    irqFlags_r <= 2'b00;
    irqEnables_r <= 2'b00;
    moduleEnable_r <= 1'b0;
    reload_request_r <= 1'b0;
    ext_reset_active_low_r <= 1'b0;
    ext_reset_immediate_r <= 1'b0;
    period_count_r <= `RST_WORD;
    sliceConfig_r <= `RST_BYTE;
    first_param_r <= `RST_WORD;
    second_param_r <= `RST_WORD;
  end else begin
    // set wins over a software clear in the same cycle
    if (wrHit && regAddr == `OFS_IRQ_FLAGS)
      irqFlags_r <= regWdata[1:0] | paramEvent;
    else
      irqFlags_r <= flagNext;
    // hardware clears reload once buffers are taken
    if (periodEvent && reload_request_r)
      reload_request_r <= 1'b0;
    if (wrHit) begin
      case (regAddr)
        `OFS_CLOCK_PRESCALE: clock_divide_setting_r <= regWdata;
        `OFS_POSTSCALE: period_event_divider_r <= regWdata;
        `OFS_IRQ_ENABLES: irqEnables_r <= regWdata[1:0];
        `OFS_MODULE_CONTROL: begin
          moduleEnable_r <= regWdata[`CON_ENABLE];
          if (!(periodEvent && reload_request_r) ||
              regWdata[`CON_RELOAD])
            reload_request_r <= regWdata[`CON_RELOAD];
          ext_reset_active_low_r <= regWdata[`CON_ERS_LOW];
          ext_reset_immediate_r <= regWdata[`CON_ERS_NOW];
        end
        `OFS_PERIOD_LOWER: period_count_r[7:0] <= regWdata;
        `OFS_PERIOD_UPPER: period_count_r[15:8] <= regWdata;
        `OFS_SLICE_CONFIG: sliceConfig_r <= regWdata;
        `OFS_FIRST_LOWER: first_param_r[7:0] <= regWdata;
        `OFS_FIRST_UPPER: first_param_r[15:8] <= regWdata;
        `OFS_SECOND_LOWER: second_param_r[7:0] <= regWdata;
        `OFS_SECOND_UPPER: second_param_r[15:8] <= regWdata;
        default: ;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// interrupt outputs
wire [1:0] enabledFlags = irqFlags_r & irqEnables_r;
always @(posedge mclk) begin
  if (reset) begin
    paramIrq <= 1'b0;
    module_irq_flag <= 1'b0;
  end else begin
    paramIrq <= |enabledFlags;
    module_irq_flag <= |enabledFlags;
  end
end

////////////////////////////////////////////////////////////////////////////
// read data, one cycle after the strobe
always @(posedge mclk) begin
  if (reset) begin
    regRdata <= `RST_BYTE;
  end else if (regRd) begin
    case (regAddr)
      `OFS_CLOCK_PRESCALE: regRdata <= clock_divide_setting_r;
      `OFS_POSTSCALE: regRdata <= period_event_divider_r;
      `OFS_IRQ_FLAGS: regRdata <= {6'h00, irqFlags_r};
      `OFS_IRQ_ENABLES: regRdata <= {6'h00, irqEnables_r};
      `OFS_MODULE_CONTROL: regRdata <= {moduleEnable_r, 4'h0,
        reload_request_r, ext_reset_active_low_r, ext_reset_immediate_r};
      `OFS_PERIOD_LOWER: regRdata <= period_count_r[7:0];
      `OFS_PERIOD_UPPER: regRdata <= period_count_r[15:8];
      `OFS_SLICE_CONFIG: regRdata <= {sliceConfig_r[7:6], 2'b00,
        sliceConfig_r[3:0]};
      `OFS_FIRST_LOWER: regRdata <= first_param_r[7:0];
      `OFS_FIRST_UPPER: regRdata <= first_param_r[15:8];
      `OFS_SECOND_LOWER: regRdata <= second_param_r[7:0];
      `OFS_SECOND_UPPER: regRdata <= second_param_r[15:8];
      `OFS_STATUS: regRdata <= {5'h00, stopped_r, |enabledFlags,
        altPhase_r};
      default: regRdata <= `RST_BYTE;
    endcase
  end else begin
    regRdata <= `RST_BYTE;
  end
end

endmodule // dual_output_pwm_slice

// ---- bench/dual_output_pwm_slice_sva.sv ----
// port assertions for the dual output pwm slice
`include "pwm_slice_defines.vh"
module dual_output_pwm_slice_sva #(
  parameter ADDR_W = 12
) (
  input wire mclk,
  input wire reset,
  input wire pwmClkEn,
  input wire extResetPin,
  input wire [ADDR_W-1:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdata,
  input wire first_output,
  input wire second_output,
  input wire periodIrq,
  input wire paramIrq,
  input wire module_irq_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [7:0] preW_r;
  reg [7:0] prdW_r;
  reg [7:0] cfgW_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // shadow of the last bytes written
  always @(posedge mclk) begin
    if (reset) begin
      preW_r <= 8'h00;
      prdW_r <= 8'h00;
      cfgW_r <= 8'h00;
    end else if (regWr) begin
      if (regAddr == `OFS_CLOCK_PRESCALE) preW_r <= regWdata;
      if (regAddr == `OFS_PERIOD_LOWER) prdW_r <= regWdata;
      if (regAddr == `OFS_SLICE_CONFIG) cfgW_r <= regWdata;
    end
  end
  a_read_slot: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside its slot");
  a_unmapped_read: assert property (regRd &&
    (regAddr < `OFS_PERIOD_LOWER || regAddr > `OFS_STATUS)
    |=> regRdata == 8'h00) else $error("unmapped read not zero");
  a_prescale_back: assert property (
    regRd && regAddr == `OFS_CLOCK_PRESCALE |=> regRdata == preW_r)
    else $error("prescale readback wrong");
  a_period_back: assert property (
    regRd && regAddr == `OFS_PERIOD_LOWER |=> regRdata == prdW_r)
    else $error("period readback wrong");
  a_config_back: assert property (
    regRd && regAddr == `OFS_SLICE_CONFIG |=> regRdata == (cfgW_r & 8'hCF))
    else $error("config readback wrong");
  a_irq_mirror: assert property (paramIrq == module_irq_flag)
    else $error("module flag differs from irq");
  a_irq_mask: assert property (regWr && regAddr == `OFS_IRQ_ENABLES &&
    regWdata[1:0] == 2'b00 |-> ##2 !paramIrq) else $error("masked irq seen");
  a_period_pulse: assert property (periodIrq |=> !periodIrq)
    else $error("period irq longer than one cycle");
  a_reset_idle: assert property ($fell(reset) |-> !first_output &&
    !second_output && !periodIrq && !paramIrq)
    else $error("outputs not idle after reset");
endmodule // dual_output_pwm_slice_sva

bind dual_output_pwm_slice dual_output_pwm_slice_sva #(.ADDR_W(ADDR_W)) u_sva (
  .mclk(mclk), .reset(reset), .pwmClkEn(pwmClkEn),
  .extResetPin(extResetPin), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .first_output(first_output), .second_output(second_output),
  .periodIrq(periodIrq), .paramIrq(paramIrq),
  .module_irq_flag(module_irq_flag));

// ---- bench/pwm_far_side.sv ----
// far side model: pwm clock source and external reset source
module pwm_far_side #(
  parameter DIV = 2
) (
  input wire mclk,
  input wire reset,
  input wire stopReq,
  input wire activeLow,
  output logic pwmClkEn,
  output logic extResetPin
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // one clock enable pulse every DIV cycles
  always @(posedge mclk) begin
    cnt <= (reset || cnt == DIV - 1) ? 0 : cnt + 1;
    pwmClkEn <= !reset && cnt == DIV - 1;
  end
  // reset source level from request and polarity
  always @(posedge mclk) extResetPin <= stopReq ^ activeLow;
endmodule // pwm_far_side

// ---- bench/dual_output_pwm_slice_test.sv ----
// self-checking bench of the dual output pwm slice
`include "pwm_slice_defines.vh"
module dual_output_pwm_slice_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset, regWr, regRd, stopReq, activeLow, pwmClkEn;
  logic extResetPin, periodIrq, paramIrq, module_irq_flag;
  logic first_output, second_output;
  logic [11:0] regAddr;
  logic [7:0] regWdata, regRdata, rd, d;
  logic [11:0] rw [8];
  int n_fail, total_checks, cyc, hi1, hi2, nIrq, per, n1, n2, sc, win;

  dual_output_pwm_slice u_dut (.mclk(mclk), .reset(reset),
    .pwmClkEn(pwmClkEn), .extResetPin(extResetPin), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .first_output(first_output),
    .second_output(second_output), .periodIrq(periodIrq),
    .paramIrq(paramIrq), .module_irq_flag(module_irq_flag));
  pwm_far_side u_far (.mclk(mclk), .reset(reset), .stopReq(stopReq),
    .activeLow(activeLow), .pwmClkEn(pwmClkEn), .extResetPin(extResetPin));

  //////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // cycle ceiling against hangs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input int e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd8(input logic [11:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(posedge mclk);
    rd = regRdata;
  endtask
  // active counts of one output over two periods
  function automatic int twoPer(input int m, input int n);
    case (m)
      0, 1: return 2 * n;
      2: return 4 * n;
      3: return 2 * (n2 - n1);
      4: return 2 * (per + 1);
      5: return per + 1;
      8: return n;
      default: return 0;
    endcase
  endfunction
  // reconfigure while disabled, then enable
  task automatic setup(input int m);
    wr(`OFS_MODULE_CONTROL, 8'h00);
    wr(`OFS_SLICE_CONFIG, (m == 8) ? 8'h88 : (8'h80 | 8'(m)));
    wr(`OFS_IRQ_FLAGS, 8'h00);
    wr(`OFS_MODULE_CONTROL, 8'h80);
  endtask
  // settle four periods, then count four periods
  task automatic measure();
    win = 4 * (per + 1) * sc;
    repeat (win) @(posedge mclk);
    hi1 = 0;
    hi2 = 0;
    nIrq = 0;
    repeat (win) begin
      @(posedge mclk);
      if ($isunknown({first_output, second_output, periodIrq}))
        chk("known outputs", 0, 1);
      hi1 += int'(first_output);
      hi2 += int'(second_output);
      nIrq += int'(periodIrq);
    end
  endtask
  initial begin
    reset = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 12'h000;
    regWdata = 8'h00;
    stopReq = 1'b0;
    activeLow = 1'b0;
    n_fail = 0;
    total_checks = 0;
    void'($urandom(22));
    rw = '{`OFS_CLOCK_PRESCALE, `OFS_POSTSCALE, `OFS_PERIOD_LOWER,
      `OFS_PERIOD_UPPER, `OFS_FIRST_LOWER, `OFS_FIRST_UPPER,
      `OFS_SECOND_LOWER, `OFS_SECOND_UPPER};
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd8(`OFS_MODULE_CONTROL);
    chk("control reset", 0, rd);
    rd8(12'h400);
    chk("unmapped", 0, rd);
    // reset values except postscale, then random byte readback
    foreach (rw[i]) begin
      rd8(rw[i]);
      if (i != 1) chk("reset value", 0, rd);
      d = 8'($urandom);
      wr(rw[i], d);
      rd8(rw[i]);
      chk("readback", d, rd);
    end
    per = 14 + $urandom % 2;
    n1 = 1 + $urandom % 3;
    n2 = n1 + 1 + $urandom % 3;
    sc = 2 * (1 + $urandom % 3);
    wr(`OFS_PERIOD_LOWER, 8'(per));
    wr(`OFS_PERIOD_UPPER, 8'h00);
    wr(`OFS_FIRST_LOWER, 8'(n1));
    wr(`OFS_FIRST_UPPER, 8'h00);
    wr(`OFS_SECOND_LOWER, 8'(n2));
    wr(`OFS_SECOND_UPPER, 8'h00);
    wr(`OFS_CLOCK_PRESCALE, 8'(sc / 2 - 1));
    wr(`OFS_POSTSCALE, 8'h01);
    wr(`OFS_IRQ_ENABLES, 8'h03);
    // every mode, second output inverted; 8 is push-pull left
    for (int m = 0; m < 9; m++) begin
      setup(m);
      measure();
      chk("out1", 2 * sc * twoPer(m, n1), hi1);
      chk("out2", win - 2 * sc * twoPer(m, n2), hi2);
      chk("periodIrq", 2, nIrq);
      if (m < 6 || m == 8) begin
        rd8(`OFS_IRQ_FLAGS);
        chk("flags", 3, rd[1:0]);
        chk("paramIrq", 1, paramIrq);
      end
    end
    wr(`OFS_IRQ_ENABLES, 8'h00);
    @(posedge mclk);
    chk("masked irq", 0, paramIrq);
    chk("module flag", 0, module_irq_flag);
    // reload a new first value while running
    setup(0);
    n1 = n1 + 2;
    wr(`OFS_FIRST_LOWER, 8'(n1));
    wr(`OFS_MODULE_CONTROL, 8'h84);
    measure();
    rd8(`OFS_MODULE_CONTROL);
    chk("reload bit", 8'h80, rd);
    chk("out1 reloaded", 4 * sc * n1, hi1);
    // external reset in both polarities and timings
    stopReq <= 1'b1;
    wr(`OFS_MODULE_CONTROL, 8'h81);
    measure();
    chk("stop now", 0, hi1);
    activeLow <= 1'b1;
    wr(`OFS_MODULE_CONTROL, 8'h82);
    measure();
    chk("stop late", 0, hi1);
    stopReq <= 1'b0;
    measure();
    chk("restart", 4 * sc * n1, hi1);
    tally_and_finish();
  end
endmodule // dual_output_pwm_slice_test
